// ### test/host_bus_model.sv
// host processor model driving the parallel bus
`timescale 1ns/1ps
module host_bus_model(
	// clock
	input  logic       i_clock,
	// answer from the device
	input  logic [7:0] i_rdat,
	input  logic       i_oe_n,
	// pins toward the device
	output logic [2:0] o_cs,
	output logic [3:0] o_st,
	output logic [2:0] o_idx,
	output logic [7:0] o_dat,
	// drive enable seen along with the read data
	output logic       o_oe_seen
);
	initial {o_cs, o_st, o_idx, o_dat} = {7'b0011010, 11'h000};
	initial o_oe_seen = 1'b1;
	// strobe held 5 edges so the synced read data has settled
	task acc(input logic [2:0] c, input logic [3:0] s, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge i_clock);
		o_cs <= c;
		o_idx <= a;
		o_dat <= d;
		o_st <= s;
		repeat (5) @(posedge i_clock);
		q = i_rdat;
		o_oe_seen = i_oe_n;
		o_cs <= 3'b001;
		o_st <= 4'b1010;
		o_dat <= ~d;
		repeat (4) @(posedge i_clock);
	endtask
endmodule // host_bus_model

// ### test/uart_host_bus_and_tx_dma_port_bench.sv
// scenarios for the host port
`timescale 1ns/1ps
module uart_host_bus_and_tx_dma_port_bench;
	logic       i_clock = 0, i_sys_rst = 1, i_tx_char_taken = 0;
	logic [2:0] cs, idx;
	logic [3:0] st;
	logic [7:0] dat, o_data, got;
	logic       oe_n, req_n, oe_seen;
	int         err_count = 0, checks = 0, cyc = 0;
	uart_host_bus_and_tx_dma_port i_uart_host_bus_and_tx_dma_port(
		.i_clock, .i_sys_rst, .i_tx_char_taken, .o_data,
		.i_chip_select_high_a(cs[2]), .i_chip_select_high_b(cs[1]),
		.i_chip_select_low_n(cs[0]), .i_write_strobe_low_n(st[3]),
		.i_write_strobe_high(st[2]), .i_read_strobe_low_n(st[1]),
		.i_read_strobe_high(st[0]), .i_register_select_lines(idx),
		.i_data(dat), .o_data_oe_n(oe_n), .o_tx_dma_request_n(req_n));
	host_bus_model i_host_bus_model(.i_clock, .i_rdat(o_data), .o_cs(cs),
		.o_st(st), .o_idx(idx), .o_dat(dat), .i_oe_n(oe_n),
		.o_oe_seen(oe_seen));
	task chk(input string n, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task w(input logic [2:0] a, input logic [7:0] d);
		i_host_bus_model.acc(3'b110, 4'b0010, a, d, got);
	endtask
	task rq(input logic e);
		repeat (2) @(posedge i_clock);
		#1 chk("request", {7'h00, req_n}, {7'h00, e});
	endtask
	task take;
		@(posedge i_clock);
		i_tx_char_taken <= 1'b1;
		@(posedge i_clock);
		i_tx_char_taken <= 1'b0;
	endtask
	task sel_scn;
		logic [2:0] bad [3];
		bad = '{3'b010, 3'b100, 3'b111};
		w(3'h7, 8'h5A);
		foreach (bad[k]) begin
			i_host_bus_model.acc(bad[k], 4'b0010, 3'h0, 8'hC3, got);
			i_host_bus_model.acc(bad[k], 4'b1110, 3'h7, 8'hA5, got);
			i_host_bus_model.acc(bad[k], 4'b1011, 3'h7, 8'h00, got);
			chk("idle drive", {7'h00, oe_seen}, 8'h01);
		end
		rq(1'b0);
		i_host_bus_model.acc(3'b110, 4'b1000, 3'h7, 8'h00, got);
		chk("scratch", got, 8'h5A);
		chk("read drive", {7'h00, oe_seen}, 8'h00);
	endtask
	task strb_scn;
		i_host_bus_model.acc(3'b110, 4'b1110, 3'h1, 8'h3C, got);
		i_host_bus_model.acc(3'b110, 4'b1011, 3'h1, 8'h00, got);
		chk("high strobes", got, 8'h3C);
		chk("high read drive", {7'h00, oe_seen}, 8'h00);
	endtask
	task mode0_scn;
		logic [7:0] fcr [3];
		fcr = '{8'h00, 8'h08, 8'h01};
		foreach (fcr[k]) begin
			w(3'h2, fcr[k]);
			rq(1'b0);
			w(3'h0, 8'h11);
			rq(1'b1);
			take;
			rq(1'b0);
		end
	endtask
	task mode1_scn;
		w(3'h2, 8'h09);
		i_host_bus_model.acc(3'b110, 4'b1000, 3'h2, 8'h00, got);
		chk("fifo control", got, 8'h09);
		for (int k = 0; k < 15; k++) w(3'h0, k[7:0]);
		rq(1'b0);
		w(3'h0, 8'hFF);
		rq(1'b1);
		take;
		rq(1'b0);
		w(3'h2, 8'h05);
		rq(1'b0);
	endtask
	task wrap_up;
		if (err_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial forever #5 i_clock = ~i_clock;
	initial begin
		repeat (6) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		sel_scn;
		strb_scn;
		mode0_scn;
		mode1_scn;
		wrap_up;
	end
	always @(posedge i_clock) if (++cyc == 2000) begin
		err_count++;
		wrap_up;
	end
endmodule // uart_host_bus_and_tx_dma_port_bench

// ### test/uart_host_port_properties.sv
// assertions on the host port pins
`timescale 1ns/1ps
module uart_host_port_properties(
	// clock and reset
	input logic i_clock,
	input logic i_sys_rst,
	// host pins
	input logic i_chip_select_high_a,
	input logic i_chip_select_high_b,
	input logic i_chip_select_low_n,
	input logic i_write_strobe_low_n,
	input logic i_write_strobe_high,
	input logic i_read_strobe_low_n,
	input logic i_read_strobe_high,
	// serial engine side
	input logic i_tx_char_taken,
	// device answers
	input logic o_data_oe_n,
	input logic o_tx_dma_request_n
);
	wire sel = i_chip_select_high_a & i_chip_select_high_b
		& ~i_chip_select_low_n;
	wire rd = sel & (~i_read_strobe_low_n | i_read_strobe_high);
	wire wr = sel & (~i_write_strobe_low_n | i_write_strobe_high);
	// cycles since the fill could last have moved, saturating
	logic [3:0] quiet;
	always @(posedge i_clock or posedge i_sys_rst)
		if (i_sys_rst) quiet <= 4'hF;
		else quiet <= (wr | i_tx_char_taken) ? 4'h0 : quiet + (quiet != 4'hF);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	chk_read_drives_bus: assert property (rd [*4] |-> !o_data_oe_n)
		else $error("read not driven");
	chk_idle_no_drive: assert property (!sel [*4] |-> o_data_oe_n)
		else $error("unselected drive");
	chk_drive_needs_select: assert property
		(!o_data_oe_n |-> $past(rd, 2) || $past(rd, 3)) else $error("stray drive");
	chk_write_no_drive: assert property ((wr & ~rd) [*4] |-> o_data_oe_n)
		else $error("drive on write");
	chk_request_after_reset: assert property
		($fell(i_sys_rst) |-> !o_tx_dma_request_n) else $error("no request");
	chk_request_held: assert property
		(quiet > 4'hA |-> $stable(o_tx_dma_request_n)) else $error("req moved");
	chk_request_rise_cause: assert property
		($rose(o_tx_dma_request_n) |-> quiet < 4'h9) else $error("late rise");
	chk_request_fall_cause: assert property
		($fell(o_tx_dma_request_n) |-> quiet < 4'h9) else $error("late fall");
endmodule // uart_host_port_properties
bind uart_host_bus_and_tx_dma_port uart_host_port_properties i_props(.*);

// ### verilog/host_reg_file.v
// small register store with registered read data
`timescale 1ns/1ps
module host_reg_file #(
	parameter WIDTH = 8,
	parameter COUNT = 8
) (
	// clock and reset
	input  wire                     i_clock,
	input  wire                     i_sys_rst,
	// write side
	input  wire                     i_write,
	input  wire [2:0]               i_write_index,
	input  wire [WIDTH-1:0]         i_write_data,
	// read side
	input  wire [2:0]               i_read_index,
	output reg  [WIDTH-1:0]         o_read_data
);
	reg [WIDTH-1:0] store [0:COUNT-1];
	genvar g;
	generate
		for (g = 0; g < COUNT; g = g + 1) begin : entry
			always @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst)
					store[g] <= {WIDTH{1'b0}};
				else if (i_write && i_write_index == g)
					store[g] <= i_write_data;
			end
		end
	endgenerate
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_read_data <= {WIDTH{1'b0}};
		else
			o_read_data <= store[i_read_index];
	end
endmodule // host_reg_file

// ### verilog/uart_host_bus_and_tx_dma_port.v
// parallel host port with transmit dma request of a serial element
`timescale 1ns/1ps
`include "uart_host_port_regs.vh"
module uart_host_bus_and_tx_dma_port #(
	parameter TX_DEPTH = `TX_FIFO_DEPTH
) (
	// clock and reset
	input  wire       i_clock,
	input  wire       i_sys_rst,
	// chip selects
	input  wire       i_chip_select_high_a,
	input  wire       i_chip_select_high_b,
	input  wire       i_chip_select_low_n,
	// strobes
	input  wire       i_write_strobe_low_n,
	input  wire       i_write_strobe_high,
	input  wire       i_read_strobe_low_n,
	input  wire       i_read_strobe_high,
	// address and data bus
	input  wire [2:0] i_register_select_lines,
	input  wire [7:0] i_data,
	output wire [7:0] o_data,
	output wire       o_data_oe_n,
	// transmit side from serial engine
	input  wire       i_tx_char_taken,
	// transmit dma request
	output reg        o_tx_dma_request_n
);
	localparam CW = 5;
	localparam PW = 18;
	localparam [PW-1:0] PIN_IDLE = `PIN_IDLE_LEVELS;

	// every pin, the data bus included, passes the same two stages, so
	// select lines, data and strobes stay aligned cycle for cycle
	wire [PW-1:0] pin_raw = {
		i_chip_select_high_a,
		i_chip_select_high_b,
		i_chip_select_low_n,
		i_write_strobe_low_n,
		i_write_strobe_high,
		i_read_strobe_low_n,
		i_read_strobe_high,
		i_register_select_lines,
		i_data
	};
	wire [PW-1:0] pin_safe;

	// each stage resets to the idle level of its pin, so no false strobe
	// or select shows when reset lifts
	genvar b;
	generate
		for (b = 0; b < PW; b = b + 1) begin : pin_sync
			reg stage1;
			reg stage2;
			always @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					stage1 <= PIN_IDLE[b];
					stage2 <= PIN_IDLE[b];
				end else begin
					stage1 <= pin_raw[b];
					stage2 <= stage1;
				end
			end
			assign pin_safe[b] = stage2;
		end
	endgenerate

	wire       cs_a    = pin_safe[17];
	wire       cs_b    = pin_safe[16];
	wire       cs_n    = pin_safe[15];
	wire       wr_n    = pin_safe[14];
	wire       wr      = pin_safe[13];
	wire       rd_n    = pin_safe[12];
	wire       rd      = pin_safe[11];
	wire [2:0] reg_sel = pin_safe[10:8];
	wire [7:0] wdata   = pin_safe[7:0];

	// all three selects must agree; one inactive select masks every strobe
	wire selected  = cs_a & cs_b & ~cs_n;
	// the unused strobe sits inactive, so an or of both suffices
	wire write_act = selected & (~wr_n | wr);
	wire read_act  = selected & (~rd_n | rd);
	// strobe end detector, reset to idle so releasing reset makes no edge
	reg  write_prev;
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			write_prev <= 1'b0;
		else
			write_prev <= write_act;
	end
	// store on strobe release, when select lines and data have settled
	wire write_pulse = write_prev & ~write_act;
	// index and data keep the last values seen while the strobe was active
	reg  [2:0] wr_index;
	reg  [7:0] wr_value;
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_index <= 3'h0;
			wr_value <= 8'h00;
		end else if (write_act) begin
			wr_index <= reg_sel;
			wr_value <= wdata;
		end
	end

	// read data leave a flop: o_data follows the select lines one cycle
	// after the synchroniser, three edges after the pins
	host_reg_file #(
		.WIDTH (8),
		.COUNT (8)
	) i_host_reg_file (
		.i_clock       (i_clock),
		.i_sys_rst     (i_sys_rst),
		.i_write       (write_pulse),
		.i_write_index (wr_index),
		.i_write_data  (wr_value),
		.i_read_index  (reg_sel),
		.o_read_data   (o_data)
	);
	assign o_data_oe_n = ~read_act;

	// fifo control copy steers the dma request; changing the fifo enable
	// empties the store, as does the flush bit
	reg fifo_on;
	reg dma_mode;
	wire fcr_write = write_pulse & (wr_index == `REG_FIFO_CTRL);
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fifo_on  <= 1'b0;
			dma_mode <= 1'b0;
		end else if (fcr_write) begin
			fifo_on  <= wr_value[`FCR_FIFO_ENABLE];
			dma_mode <= wr_value[`FCR_DMA_MODE];
		end
	end
	wire mode1 = fifo_on & dma_mode;

	// transmit fill level, one byte per data write, drained by engine
	// the parameter is a 32 bit integer and only its low bits reach the
	// count, so TX_DEPTH must stay below 32
	wire [31:0]   depth_word = TX_DEPTH;
	wire [CW-1:0] depth = fifo_on ? depth_word[CW-1:0] : 5'h01;
	reg  [CW-1:0] fill;
	// a data write beyond the level is dropped instead of wrapping the count
	wire push = write_pulse & (wr_index == `REG_DATA) & (fill < depth);
	// the serial engine takes at most one byte per cycle
	wire pop  = i_tx_char_taken & (fill != 5'h00);
	wire flush = fcr_write & (wr_value[`FCR_TX_RESET] |
		(wr_value[`FCR_FIFO_ENABLE] != fifo_on));
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst)
			fill <= 5'h00;
		else if (flush)
			fill <= 5'h00;
		else if (push & ~pop)
			fill <= fill + 5'h01;
		else if (pop & ~push)
			fill <= fill - 5'h01;
	end

	// request state: mode 0 asks for one byte and waits for it to drain,
	// mode 1 keeps asking until the store is full; leaving mode 1 with
	// bytes still held lands in the hold state until they drain
	localparam ST_ASK  = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_FILL = 2'h2;
	localparam ST_FULL = 2'h3;

	reg  [1:0] state;
	reg  [1:0] next_state;
	reg        next_req_n;
	wire       has_byte = (fill != 5'h00);
	wire       at_full  = (fill >= depth);
	always @* begin
		next_state = state;
		if (mode1) begin
			if (at_full)
				next_state = ST_FULL;
			else
				next_state = ST_FILL;
		end else begin
			case (state)
				ST_HOLD, ST_FULL: begin
					if (has_byte)
						next_state = ST_HOLD;
					else
						next_state = ST_ASK;
				end
				ST_ASK, ST_FILL: begin
					if (push | has_byte)
						next_state = ST_HOLD;
					else
						next_state = ST_ASK;
				end
				// two bits cover every code; this is only a safe landing
				default:
					next_state = ST_ASK;
			endcase
		end
		next_req_n = (next_state == ST_HOLD) | (next_state == ST_FULL);
	end

	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state              <= `REQ_STATE_RESET;
			o_tx_dma_request_n <= `REQ_RESET_LEVEL;
		end else begin
			state              <= next_state;
			o_tx_dma_request_n <= next_req_n;
		end
	end
endmodule // uart_host_bus_and_tx_dma_port

// ### verilog/uart_host_port_regs.vh
// register indices, field positions and reset values of the host port
`ifndef UART_HOST_PORT_REGS_VH
`define UART_HOST_PORT_REGS_VH
`define REG_DATA        3'h0
`define REG_IRQ_ENABLE  3'h1
`define REG_FIFO_CTRL   3'h2
`define REG_LINE_CTRL   3'h3
`define REG_MODEM_CTRL  3'h4
`define REG_LINE_STATUS 3'h5
`define REG_MODEM_STAT  3'h6
`define REG_SCRATCH     3'h7
`define FCR_FIFO_ENABLE 0
`define FCR_TX_RESET    2
`define FCR_DMA_MODE    3
`define REG_RESET_VALUE 8'h00
`define TX_FIFO_DEPTH   16
// idle levels of the synchronised pins: selects off, strobes released
`define PIN_IDLE_LEVELS 18'h0D000
`define REQ_STATE_RESET 2'h0
`define REQ_RESET_LEVEL 1'h0
`endif
